// file: hw/bus_monitor.sv
// Bus timeout monitor, counting from start strobe to final termination.
module bus_monitor
   import irq_prot_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_start,
   input wire logic i_done,
   input wire logic i_internal,
   input wire logic i_enable,
   input wire logic [1:0] i_sel,
   output logic o_timeout
);
   logic [10:0] cnt;
   logic run;
   logic internal;
   logic [10:0] limit;

   // Limit decode from the timing field.
   always_comb
   begin
      case (i_sel)
         2'h0: limit = 11'(MON_T0);
         2'h1: limit = 11'(MON_T1);
         2'h2: limit = 11'(MON_T2);
         default: limit = 11'(MON_T3);
      endcase
   end

   // Counter runs from the strobe cycle; stops after the final termination.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         cnt <= 11'h000;
         run <= 1'b0;
         internal <= 1'b0;
      end
      else if (i_start)
      begin
         cnt <= 11'h001;
         run <= !i_done;
         internal <= i_internal;
      end
      else if (run && (i_done || o_timeout))
      begin
         run <= 1'b0;
      end
      else if (run)
      begin
         cnt <= cnt + 11'h001;
      end
   end

   // Internal cycles are always watched; external only when enabled.
   assign o_timeout = run && cnt >= limit && (internal || i_enable);

   AST_TIMEOUT_BOUND: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      o_timeout |-> cnt >= 11'(MON_T0)) else $error("timeout before least limit");
   AST_EXT_GATED: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (o_timeout && !internal) |-> i_enable) else $error("disabled external timed out");
endmodule : bus_monitor

// file: hw/irq_arbiter.sv
// Selects the highest level, then highest priority, of the active sources.
module irq_arbiter
   import irq_prot_pkg::*;
(
   irq_req_if.arb bus
);
   // ==========================================================
   // Priority search
   // ==========================================================
   // A linear scan suffices; unique level/priority pairs are a software duty.
   always_comb
   begin
      logic [4:0] best_key;
      best_key = 5'h00;
      bus.best_lvl = LVL_NONE;
      bus.best_src = 4'h0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         if (bus.active[i] && {bus.lvl[i], bus.pri[i]} > best_key)
         begin
            best_key = {bus.lvl[i], bus.pri[i]};
            bus.best_lvl = bus.lvl[i];
            bus.best_src = 4'(i);
         end
      end
   end
endmodule : irq_arbiter

// file: hw/irq_protection.sv
// Interrupt controller with base decode, bus monitor and software watchdog.
module irq_protection
   import irq_prot_pkg::*;
#(
   parameter int WDOG_LIMIT = WDOG_DEFAULT
)
(
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   // Base register write and address decode.
   input wire logic I_BASE_WE,
   input wire logic [BASE_BITS-1:0] I_BASE_ADDR,
   input wire logic [SPACE_BITS-1:0] I_BASE_SPACE_MASK,
   input wire logic I_BASE_VALID,
   input wire logic [31:0] I_ACC_ADDR,
   input wire logic [SPACE_BITS-1:0] I_ACC_SPACE,
   output logic O_INTERNAL_HIT,
   output logic O_EXTERNAL_CYCLE,
   // Bus cycle tracking.
   input wire logic I_BUS_CYCLE_BEGIN_STROBE_N,
   input wire logic I_SYNC_CYCLE_ACK_N,
   input wire logic I_ASYNC_CYCLE_ACK_N,
   input wire logic I_BUS_ERROR_ACK_N,
   input wire logic I_LAST_ACK,
   output logic O_INT_BUS_ERROR,
   // Protection control, write-once; watchdog service, vector and reset-out controls.
   input wire logic I_PROT_WE,
   input wire logic I_PROT_MON_EN,
   input wire logic [1:0] I_PROT_MON_SEL,
   input wire logic I_PROT_WDOG_EN,
   input wire logic I_PROT_WDOG_RESET_SEL,
   output logic O_PROT_LOCKED,
   input wire logic I_WDOG_SVC_WE,
   input wire logic [7:0] I_WDOG_SVC_DATA,
   input wire logic I_WDOG_VEC_WE,
   input wire logic [7:0] I_WDOG_VEC_DATA,
   input wire logic I_RESET_OUT_PIN_SEL,
   output logic O_RESET_OUT_PIN_N,
   output logic O_INTERNAL_RESET,
   output logic O_WDOG_RESET_CAUSE,
   // Interrupt sources and configuration.
   input wire logic I_ENCODED_MODE,
   input wire logic [2:0] I_EXT_IRQ_N,
   input wire logic [NUM_SRC-1:0] I_INT_REQ,
   input wire logic [NUM_SRC-1:0] I_MASK,
   input wire logic I_CTRL_WE,
   input wire logic [3:0] I_CTRL_SEL,
   input wire logic [2:0] I_CTRL_LVL,
   input wire logic [1:0] I_CTRL_PRI,
   input wire logic I_CTRL_AUTOVECTOR_SELECT,
   output logic [NUM_SRC-1:0] O_PENDING,
   output logic [2:0] O_CORE_IPL,
   // Acknowledge cycle.
   input wire logic I_ACK_START,
   input wire logic [2:0] I_ACK_LVL,
   input wire logic [7:0] I_EXT_DATA,
   input wire logic [7:0] I_UART_VECTOR,
   output logic O_ACK_DONE,
   output logic [7:0] O_ACK_VECTOR,
   output logic O_ACK_AUTOVEC,
   output logic O_ACK_EXTERNAL,
   output logic [27:0] O_ACK_ADDR,
   output logic [1:0] O_ACK_TT
);
   // ==========================================================
   // Input synchronisers
   // ==========================================================
   logic [2:0] ext_s1, ext_s2, ext_s3;
   logic ts_s1, ts_s2, ta_s1, ta_s2, ata_s1, ata_s2, tea_s1, tea_s2;

   // Bus pins pass two flops, interrupt pins three; the first stage feeds only the second.
   always_ff @(posedge I_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         {ext_s1, ext_s2, ext_s3} <= 9'h1FF;
         {ts_s1, ts_s2, ta_s1, ta_s2, ata_s1, ata_s2, tea_s1, tea_s2} <= 8'hFF;
      end
      else
      begin
         ext_s1 <= I_EXT_IRQ_N;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
         {ts_s1, ta_s1, ata_s1, tea_s1} <= {I_BUS_CYCLE_BEGIN_STROBE_N, I_SYNC_CYCLE_ACK_N,
                                            I_ASYNC_CYCLE_ACK_N, I_BUS_ERROR_ACK_N};
         {ts_s2, ta_s2, ata_s2, tea_s2} <= {ts_s1, ta_s1, ata_s1, tea_s1};
      end
   end

   // ==========================================================
   // Base register and decode
   // ==========================================================
   logic base_valid;
   logic [BASE_BITS-1:0] base_addr;
   logic [SPACE_BITS-1:0] base_mask;

   // Only the valid flag has a reset value.
   always_ff @(posedge I_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
         base_valid <= 1'b0;
      else if (I_BASE_WE)
         base_valid <= I_BASE_VALID;
   end

   // Address and masks are left uninitialised like the real register.
   always_ff @(posedge I_CLK)
   begin
      if (I_BASE_WE)
      begin
         base_addr <= I_BASE_ADDR;
         base_mask <= I_BASE_SPACE_MASK;
      end
   end

   logic base_match;
   assign base_match = base_valid && I_ACC_ADDR[31:32-BASE_BITS] == base_addr;
   assign O_INTERNAL_HIT = base_match && !(|(base_mask & I_ACC_SPACE));
   assign O_EXTERNAL_CYCLE = !O_INTERNAL_HIT;

   // ==========================================================
   // Protection control and bus monitor
   // ==========================================================
   logic prot_locked, mon_en, wdog_en, wdog_rst_sel;
   logic [1:0] mon_sel;

   // First write after reset wins; later writes are dropped.
   always_ff @(posedge I_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         prot_locked <= 1'b0;
         {mon_en, wdog_en, wdog_rst_sel} <= 3'h0;
         mon_sel <= 2'h0;
      end
      else if (I_PROT_WE && !prot_locked)
      begin
         prot_locked <= 1'b1;
         {mon_en, wdog_en, wdog_rst_sel} <= {I_PROT_MON_EN, I_PROT_WDOG_EN, I_PROT_WDOG_RESET_SEL};
         mon_sel <= I_PROT_MON_SEL;
      end
   end
   assign O_PROT_LOCKED = prot_locked;

   logic mon_timeout, term_done;
   assign term_done = (!ta_s2 || !ata_s2) && I_LAST_ACK;

   bus_monitor u_mon (
      .i_clk(I_CLK),
      .i_arst_n(I_ARST_N),
      .i_start(!ts_s2),
      .i_done(term_done),
      .i_internal(O_INTERNAL_HIT),
      .i_enable(mon_en),
      .i_sel(mon_sel),
      .o_timeout(mon_timeout)
   );
   assign O_INT_BUS_ERROR = mon_timeout;

   // ==========================================================
   // Software watchdog
   // ==========================================================
   logic [31:0] wdog_cnt;
   logic wdog_key1, wdog_irq;
   logic [7:0] wdog_vec;
   logic [5:0] reset_out_pin_cnt;
   logic wdog_cause;

   // Service needs the first key then the second key.
   always_ff @(posedge I_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         wdog_cnt <= 32'h0000_0000;
         wdog_key1 <= 1'b0;
         wdog_irq <= 1'b0;
      end
      else if (!wdog_en)
         wdog_cnt <= 32'h0000_0000;
      else if (I_WDOG_SVC_WE && wdog_key1 && I_WDOG_SVC_DATA == SVC_KEY2)
      begin
         wdog_cnt <= 32'h0000_0000;
         wdog_key1 <= 1'b0;
      end
      else if (wdog_cnt >= 32'(WDOG_LIMIT - 1))
      begin
         wdog_cnt <= 32'h0000_0000;
         wdog_irq <= !wdog_rst_sel;
      end
      else
      begin
         wdog_cnt <= wdog_cnt + 32'h0000_0001;
         if (I_WDOG_SVC_WE)
            wdog_key1 <= I_WDOG_SVC_DATA == SVC_KEY1;
      end
   end

   logic wdog_fire;
   assign wdog_fire = wdog_en && wdog_rst_sel && wdog_cnt >= 32'(WDOG_LIMIT - 1);

   // Reset-out stretches to its fixed width; cause stays until power reset.
   always_ff @(posedge I_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         reset_out_pin_cnt <= 6'h00;
         wdog_cause <= 1'b0;
         wdog_vec <= WDOG_VECTOR_RST;
      end
      else
      begin
         if (wdog_fire)
         begin
            reset_out_pin_cnt <= 6'(RESET_OUT_PIN_CYCLES);
            wdog_cause <= 1'b1;
         end
         else if (reset_out_pin_cnt != 6'h00)
            reset_out_pin_cnt <= reset_out_pin_cnt - 6'h01;
         if (I_WDOG_VEC_WE)
            wdog_vec <= I_WDOG_VEC_DATA;
      end
   end
   assign O_INTERNAL_RESET = reset_out_pin_cnt != 6'h00;
   assign O_RESET_OUT_PIN_N = !(I_RESET_OUT_PIN_SEL && reset_out_pin_cnt != 6'h00);
   assign O_WDOG_RESET_CAUSE = wdog_cause;

   AST_RESET_OUT_PIN_WIDTH: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
      wdog_fire |=> (reset_out_pin_cnt == 6'(RESET_OUT_PIN_CYCLES))) else $error("reset out width wrong");

   // ==========================================================
   // Interrupt control registers
   // ==========================================================
   logic [2:0] lvl [NUM_SRC];
   logic [1:0] pri [NUM_SRC];
   logic [NUM_SRC-1:0] autovector_select;
   irq_req_if req ();

   // Per-source level, priority and autovector with fixed fields.
   for (genvar g = 0; g < NUM_SRC; g++)
   begin : g_ctrl
      logic [2:0] fixed_lvl;
      assign fixed_lvl = (g < 3) ? LVL_ONE : (g == 3 || g == 4) ? LVL_FOUR : LVL_SEVEN;
      always_ff @(posedge I_CLK or negedge I_ARST_N)
      begin
         if (!I_ARST_N)
         begin
            lvl[g] <= (g == SRC_WDOG || g < 7) ? 3'(g < 7 ? g + 1 : 7) : LVL_NONE;
            pri[g] <= 2'h0;
            autovector_select[g] <= (g >= SRC_TMR1 && g <= SRC_SBUS);
         end
         else if (I_CTRL_WE && I_CTRL_SEL == 4'(g))
         begin
            pri[g] <= I_CTRL_PRI;
            if (g != SRC_WDOG && !(g < 7 && !I_ENCODED_MODE))
               lvl[g] <= I_CTRL_LVL;
            if (g < 7 || g == SRC_UART1 || g == SRC_UART2)
               autovector_select[g] <= I_CTRL_AUTOVECTOR_SELECT;
         end
      end
      // Discrete mode forces 1/4/7; the watchdog sits at level 7.
      assign req.lvl[g] = (g == SRC_WDOG) ? LVL_SEVEN
                        : (g < 7 && !I_ENCODED_MODE) ? fixed_lvl : lvl[g];
      assign req.pri[g] = pri[g];
   end

   // ==========================================================
   // Pending logic
   // ==========================================================
   logic [2:0] enc_lvl, enc_prev, enc_held;
   logic [NUM_SRC-1:0] pending;
   logic [6:0] ext_pend;
   logic [2:0] ext_disc;

   // Inverted active-low lines; the all-high pattern decodes to none.
   assign enc_lvl = ~ext_s3;
   assign ext_disc = ~(ext_s3 | ext_s2); // Lines 0, 1, 2 carry levels 1, 4, 7 and must stand two cycles.

   // Encoded level must repeat for two cycles before it counts.
   always_ff @(posedge I_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         enc_prev <= LVL_NONE;
         enc_held <= LVL_NONE;
      end
      else
      begin
         enc_prev <= enc_lvl;
         if (enc_lvl == enc_prev)
            enc_held <= enc_lvl;
      end
   end

   // External pending vector: one bit per encoded level, or three discrete lines.
   always_ff @(posedge I_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
         ext_pend <= 7'h00;
      else if (I_ENCODED_MODE)
      begin
         for (int l = 1; l <= 7; l++)
         begin
            if (enc_held == 3'(l))
               ext_pend[l-1] <= 1'b1;
            else if (enc_held < 3'(l) || (O_ACK_DONE && I_ACK_LVL == 3'(l)))
               ext_pend[l-1] <= 1'b0;
         end
      end
      else
         ext_pend <= {ext_disc[2], 2'h0, ext_disc[1], 2'h0, ext_disc[0]};
   end

   // Internal requests set pending the clock after; masking does not gate it.
   always_ff @(posedge I_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
         pending <= '0;
      else
      begin
         pending[6:0] <= ext_pend;
         pending[NUM_SRC-1:7] <= I_INT_REQ[NUM_SRC-1:7] | {7'h00, wdog_irq};
      end
   end
   assign O_PENDING = pending;
   assign req.active = pending & ~I_MASK;

   irq_arbiter u_arb (
      .bus(req.arb)
   );
   assign O_CORE_IPL = req.best_lvl;

   // ==========================================================
   // Acknowledge cycle
   // ==========================================================
   typedef enum {ACK_IDLE, ACK_EXT, ACK_DONE} ack_state_t;
   ack_state_t ack_state, next_ack_state;
   logic [3:0] ack_src;
   logic ack_none;

   // Pick the winning source at the acknowledged level.
   always_comb
   begin
      logic [2:0] best;
      best = 3'h0;
      ack_src = 4'h0;
      ack_none = 1'b1;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         if (req.active[i] && req.lvl[i] == I_ACK_LVL && (ack_none || req.pri[i] > best))
         begin
            ack_none = 1'b0;
            best = {1'b0, req.pri[i]};
            ack_src = 4'(i);
         end
      end
   end

   // Next state of the acknowledge sequencer.
   always_comb
   begin
      next_ack_state = ack_state;
      case (ack_state)
         ACK_IDLE: if (I_ACK_START) next_ack_state = (ack_none || autovector_select[ack_src] || ack_src >= 4'(7))
                                                     ? ACK_DONE : ACK_EXT;
         ACK_EXT: if (!ta_s2 || !ata_s2 || !tea_s2) next_ack_state = ACK_DONE;
         default: next_ack_state = ACK_IDLE;
      endcase
   end

   // Vector, autovector and external-cycle registers.
   always_ff @(posedge I_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         ack_state <= ACK_IDLE;
         O_ACK_VECTOR <= 8'h00;
         O_ACK_AUTOVEC <= 1'b0;
         O_ACK_EXTERNAL <= 1'b0;
      end
      else
      begin
         ack_state <= next_ack_state;
         if (ack_state == ACK_IDLE && I_ACK_START)
         begin
            O_ACK_EXTERNAL <= next_ack_state == ACK_EXT;
            O_ACK_AUTOVEC <= !ack_none && autovector_select[ack_src] && ack_src != 4'(SRC_WDOG);
            O_ACK_VECTOR <= ack_none ? SPURIOUS_VECTOR
                          : (ack_src == 4'(SRC_WDOG)) ? wdog_vec
                          : I_UART_VECTOR;
         end
         else if (ack_state == ACK_EXT && next_ack_state == ACK_DONE)
         begin
            O_ACK_EXTERNAL <= 1'b0;
            O_ACK_VECTOR <= !tea_s2 ? SPURIOUS_VECTOR : I_EXT_DATA;
         end
      end
   end
   assign O_ACK_DONE = ack_state == ACK_DONE;
   // Acknowledge address: all ones high, level in 4:2, low bits zero.
   assign O_ACK_ADDR = O_ACK_EXTERNAL ? {23'h7FFFFF, I_ACK_LVL, 2'h0} : 28'h0000000;
   assign O_ACK_TT = O_ACK_EXTERNAL ? 2'h3 : 2'h0;

   AST_SPURIOUS: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
      (ack_state == ACK_IDLE && I_ACK_START && ack_none) |=> (O_ACK_DONE && O_ACK_VECTOR == SPURIOUS_VECTOR))
      else $error("spurious vector missing");
   AST_PROT_LOCK: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
      prot_locked |=> $stable(mon_sel) && $stable(wdog_en)) else $error("locked control changed");
   AST_BASE_OFF: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
      !base_valid |-> !O_INTERNAL_HIT) else $error("decode with base invalid");
   AST_DISC_LVL: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
      !I_ENCODED_MODE |-> req.lvl[0] == LVL_ONE && req.lvl[6] == LVL_SEVEN) else $error("discrete level");
   AST_WDOG_LVL: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
      req.lvl[SRC_WDOG] == LVL_SEVEN) else $error("watchdog level not seven");
   AST_INT_PEND: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
      I_INT_REQ[SRC_TMR1] |=> pending[SRC_TMR1]) else $error("internal pending late");
   AST_ACK_ADDR: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
      O_ACK_EXTERNAL |-> O_ACK_ADDR[4:2] == I_ACK_LVL && O_ACK_ADDR[1:0] == 2'h0) else $error("ack address");
   AST_TIMER_AUTOVECTOR_SELECT: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
      autovector_select[SRC_TMR1] && autovector_select[SRC_SBUS]) else $error("fixed autovector cleared");
endmodule : irq_protection

// file: shared/irq_prot_pkg.sv
// Behaviour
// - Reset clears base valid flag only.
// - Valid base compares upper 22 address bits.
// - Masked address space goes to external bus.
// - Monitor limit selectable 128/256/512/1024 cycles.
// - Timeout asserts internal bus error acknowledge.
// - Count from start strobe to final termination.
// - Enable bit gates external cycles only.
// - Protection control accepts first write only.
// - Vector 24 on error or nothing pending.
// - Watchdog timeout: reset or level 7 interrupt.
// - Watchdog reset sets cause, pulses reset 32.
// - Requests valid after two consecutive clocks.
// - Discrete mode levels fixed 1, 4, 7.
// - Encoded lines decode to level 1..7.
// - External priority and autovector bits writable.
// - Watchdog level 7, autovector reads zero.
// - Timer and serial-bus autovector fixed one.
// - UART autovector writable; zero means UART vector.
// - Pending and mask bits; present highest unmasked.
// - Pending sets clock after (synchronised) request.
// - Encoded pending: hold, rise keep, fall clear.
// - External acknowledge drives level on address.
package irq_prot_pkg;
   // ==========================================================
   // Sources and fields
   // ==========================================================
   localparam int NUM_SRC = 15;
   localparam int SRC_WDOG = 7;
   localparam int SRC_TMR1 = 8;
   localparam int SRC_TMR2 = 9;
   localparam int SRC_SBUS = 10;
   localparam int SRC_UART1 = 11;
   localparam int SRC_UART2 = 12;
   localparam logic [2:0] LVL_NONE = 3'h0;
   localparam logic [2:0] LVL_ONE = 3'h1;
   localparam logic [2:0] LVL_FOUR = 3'h4;
   localparam logic [2:0] LVL_SEVEN = 3'h7;
   localparam logic [7:0] SPURIOUS_VECTOR = 8'h18;
   localparam logic [7:0] WDOG_VECTOR_RST = 8'h0F;
   localparam int BASE_BITS = 22;
   localparam int SPACE_BITS = 5;
   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_NS = 100;
   localparam int MON_T0 = 128;
   localparam int MON_T1 = 256;
   localparam int MON_T2 = 512;
   localparam int MON_T3 = 1024;
   localparam int RESET_OUT_PIN_NS = 3200;
   localparam int RESET_OUT_PIN_CYCLES = (RESET_OUT_PIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int WDOG_DEFAULT = 65536;
   // Watchdog service keys.
   localparam logic [7:0] SVC_KEY1 = 8'h55;
   localparam logic [7:0] SVC_KEY2 = 8'hAA;
endpackage : irq_prot_pkg

// file: shared/irq_req_if.sv
// Carries request levels and priorities to the arbiter.
interface irq_req_if;
   import irq_prot_pkg::*;
   logic [NUM_SRC-1:0] active;
   logic [2:0] lvl [NUM_SRC];
   logic [1:0] pri [NUM_SRC];
   logic [2:0] best_lvl;
   logic [3:0] best_src;
   modport ctrl (output active, output lvl, output pri, input best_lvl, input best_src);
   modport arb (input active, input lvl, input pri, output best_lvl, output best_src);
endinterface : irq_req_if

// file: verif/ext_responder.sv
// ==========================================================
// External responder for acknowledge cycles
// ==========================================================
// Mode 0 answers with a vector, mode 1 with a bus error, mode 2 stays silent.
module ext_responder (
   input wire logic i_clk,
   input wire logic i_req,
   input wire logic [1:0] i_mode,
   input wire logic [7:0] i_vec,
   output logic o_ack_n,
   output logic o_err_n,
   output logic [7:0] o_data
);
   timeunit 1ns;
   timeprecision 1ns;
   int wait_cnt;
   // Lines start released; the data bus starts at zero and, outside a mode 0 request, flips to the inverse of its last value each cycle.
   initial
   begin
      wait_cnt = 0;
      o_ack_n = 1'b1;
      o_err_n = 1'b1;
      o_data = 8'h00;
   end
   // A two-cycle wait proves the design really waits for the answer.
   // The answer lasts one cycle, so its synchronised copy cannot end the next acknowledge too.
   always @(posedge i_clk)
   begin
      wait_cnt <= i_req ? wait_cnt + 1 : 0;
      o_ack_n <= !(i_req && wait_cnt == 2 && i_mode == 2'h0);
      o_err_n <= !(i_req && wait_cnt == 2 && i_mode == 2'h1);
      o_data <= (i_req && i_mode == 2'h0) ? i_vec : ~o_data;
   end
endmodule : ext_responder

// file: verif/irq_protection_test.sv
// ==========================================================
// Testbench
// ==========================================================
module irq_protection_test;
   timeunit 1ns;
   timeprecision 1ns;
   import irq_prot_pkg::*;
   logic I_CLK, I_ARST_N, I_BASE_WE, I_BASE_VALID, I_BUS_CYCLE_BEGIN_STROBE_N, I_ASYNC_CYCLE_ACK_N, I_LAST_ACK;
   logic I_PROT_WE, I_PROT_MON_EN, I_PROT_WDOG_EN, I_PROT_WDOG_RESET_SEL, I_WDOG_SVC_WE, I_WDOG_VEC_WE;
   logic I_RESET_OUT_PIN_SEL, I_ENCODED_MODE, I_CTRL_WE, I_CTRL_AUTOVECTOR_SELECT, I_ACK_START;
   logic [21:0] I_BASE_ADDR;
   logic [4:0] I_BASE_SPACE_MASK, I_ACC_SPACE;
   logic [31:0] I_ACC_ADDR;
   logic [1:0] I_PROT_MON_SEL, I_CTRL_PRI, O_ACK_TT, rsp_mode;
   logic [7:0] I_WDOG_SVC_DATA, I_WDOG_VEC_DATA, I_UART_VECTOR, O_ACK_VECTOR;
   logic [2:0] I_EXT_IRQ_N, I_CTRL_LVL, I_ACK_LVL, O_CORE_IPL;
   logic [14:0] I_INT_REQ, I_MASK, O_PENDING;
   logic [3:0] I_CTRL_SEL;
   logic [27:0] O_ACK_ADDR;
   logic O_INTERNAL_HIT, O_EXTERNAL_CYCLE, O_INT_BUS_ERROR, O_PROT_LOCKED, O_RESET_OUT_PIN_N, O_INTERNAL_RESET;
   logic O_WDOG_RESET_CAUSE, O_ACK_DONE, O_ACK_AUTOVEC, O_ACK_EXTERNAL;
   wire logic I_SYNC_CYCLE_ACK_N, I_BUS_ERROR_ACK_N;
   wire logic [7:0] I_EXT_DATA;
   int mismatches = 0;
   int samples_checked = 0;
   int n;

   // The ports share their names with the signals above, so implicit named connection is used.
   irq_protection #(.WDOG_LIMIT(64)) irq_protection_i (.*);
   ext_responder ext_responder_i (.i_clk(I_CLK), .i_req(O_ACK_EXTERNAL), .i_mode(rsp_mode), .i_vec(8'h40),
      .o_ack_n(I_SYNC_CYCLE_ACK_N), .o_err_n(I_BUS_ERROR_ACK_N), .o_data(I_EXT_DATA));

   // Free-running system clock.
   initial
   begin
      I_CLK = 1'b0;
      forever #50 I_CLK = ~I_CLK;
   end

   task step(input int cnt);
      repeat (cnt) @(posedge I_CLK);
      #1;
   endtask : step

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Runs one acknowledge cycle; an autovectored answer carries no vector worth comparing.
   task ack(input logic [2:0] lvl, input logic [1:0] mode, input logic [7:0] vec, input logic ext, input logic av);
      logic saw_ext;
      saw_ext = 1'b0;
      rsp_mode = mode;
      I_ACK_LVL = lvl;
      I_ACK_START = 1'b1;
      step(1);
      I_ACK_START = 1'b0;
      for (n = 0; n < 30 && O_ACK_DONE !== 1'b1; n++)
      begin
         if (O_ACK_EXTERNAL === 1'b1)
            saw_ext = 1'b1;
         if (O_ACK_EXTERNAL === 1'b1)
            chk("ack address", {2'h3, 23'h7FFFFF, lvl, 2'h0}, {O_ACK_TT, O_ACK_ADDR});
         step(1);
      end
      chk("ack done", 1, n < 30);
      chk("ack external", ext, saw_ext);
      if (av)
         chk("ack autovector", 1, O_ACK_AUTOVEC);
      else
         chk("ack vector", vec, O_ACK_VECTOR);
      step(1);
   endtask : ack

   task print_verdict;
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict

   // Main sequence.
   initial
   begin
      {I_ARST_N, I_BASE_WE, I_BASE_VALID, I_LAST_ACK, I_PROT_WE, I_PROT_MON_EN, I_WDOG_SVC_WE, I_WDOG_VEC_WE} = '0;
      {I_ENCODED_MODE, I_CTRL_WE, I_CTRL_AUTOVECTOR_SELECT, I_ACK_START, I_CTRL_SEL, I_CTRL_LVL, I_CTRL_PRI, I_ACK_LVL} = '0;
      {I_BASE_SPACE_MASK, I_ACC_SPACE, I_PROT_MON_SEL, I_WDOG_SVC_DATA, I_WDOG_VEC_DATA, I_UART_VECTOR} = '0;
      {I_INT_REQ, I_MASK, rsp_mode} = '0;
      {I_BUS_CYCLE_BEGIN_STROBE_N, I_ASYNC_CYCLE_ACK_N, I_PROT_WDOG_EN, I_PROT_WDOG_RESET_SEL} = 4'hF;
      I_RESET_OUT_PIN_SEL = 1'b1;
      I_EXT_IRQ_N = 3'h7;
      I_BASE_ADDR = 22'h12345;
      I_ACC_ADDR = 32'h048D1410;
      step(5);
      I_ARST_N = 1'b1;
      step(1);
      chk("hit before base write", 0, O_INTERNAL_HIT);
      I_PROT_WE = 1'b1;
      step(1);
      {I_PROT_MON_SEL, I_PROT_WDOG_EN} = 3'h6;
      step(1);
      I_PROT_WE = 1'b0;
      chk("protection locked", 1, O_PROT_LOCKED);
      for (n = 0; n < 200 && O_RESET_OUT_PIN_N !== 1'b0; n++) step(1);
      chk("watchdog fired", 1, n < 200);
      chk("internal reset", 1, O_INTERNAL_RESET);
      for (n = 0; n < 50 && O_RESET_OUT_PIN_N === 1'b0; n++) step(1);
      chk("reset pin cycles", 32, n);
      chk("watchdog cause", 1, O_WDOG_RESET_CAUSE);
      {I_BASE_WE, I_BASE_VALID, I_BASE_SPACE_MASK, I_ACC_SPACE} = 12'hC22;
      step(1);
      I_BASE_WE = 1'b0;
      chk("internal hit", 1, O_INTERNAL_HIT);
      I_ACC_SPACE = 5'h01;
      step(1);
      chk("masked space external", 1, O_EXTERNAL_CYCLE);
      I_ACC_SPACE = 5'h02;
      I_BUS_CYCLE_BEGIN_STROBE_N = 1'b0;
      step(1);
      I_BUS_CYCLE_BEGIN_STROBE_N = 1'b1;
      for (n = 1; n < 200 && O_INT_BUS_ERROR !== 1'b1; n++) step(1);
      chk("monitor limit", 1, n >= MON_T0 && n <= MON_T0 + 4);
      I_ACC_SPACE = 5'h01;
      I_BUS_CYCLE_BEGIN_STROBE_N = 1'b0;
      step(1);
      I_BUS_CYCLE_BEGIN_STROBE_N = 1'b1;
      for (n = 0; n < 140 && O_INT_BUS_ERROR !== 1'b1; n++) step(1);
      chk("external unmonitored", 140, n);
      {I_CTRL_WE, I_CTRL_SEL, I_CTRL_LVL} = 8'hC3;
      I_INT_REQ[SRC_TMR1] = 1'b1;
      step(1);
      {I_CTRL_WE, I_CTRL_SEL, I_CTRL_LVL} = 8'hB2;
      step(2);
      I_CTRL_WE = 1'b0;
      chk("timer pending", 1, O_PENDING[SRC_TMR1]);
      chk("timer level", 3, O_CORE_IPL);
      I_MASK[SRC_TMR1] = 1'b1;
      step(1);
      chk("masked level", 0, O_CORE_IPL);
      I_MASK = '0;
      I_EXT_IRQ_N = 3'h3;
      step(5);
      chk("discrete pending", 1, O_PENDING[6]);
      chk("discrete fixed level", 7, O_CORE_IPL);
      ack(3'h3, 2'h0, 8'h00, 1'b0, 1'b1);
      ack(3'h7, 2'h0, 8'h40, 1'b1, 1'b0);
      ack(3'h7, 2'h1, SPURIOUS_VECTOR, 1'b1, 1'b0);
      I_EXT_IRQ_N = 3'h7;
      step(3);
      ack(3'h2, 2'h0, SPURIOUS_VECTOR, 1'b0, 1'b0);
      I_ENCODED_MODE = 1'b1;
      I_EXT_IRQ_N = 3'h2;
      step(8);
      chk("encoded level five", 5, O_CORE_IPL);
      I_EXT_IRQ_N = 3'h1;
      step(8);
      chk("encoded rise keeps", 2'h3, O_PENDING[5:4]);
      I_EXT_IRQ_N = 3'h5;
      step(8);
      chk("encoded fall clears", 7'h02, O_PENDING[6:0]);
      print_verdict();
   end
endmodule : irq_protection_test
